// ===== verilog/mbm_pkg.sv
// package of the memory block move engine: widths, opcodes, limits.
// assumes a byte-wide ram of at most 1024 bytes and a 128-byte rx queue.
`default_nettype none

package mbm_pkg;

    localparam int unsigned ADDR_W = 10;  // ram byte address width
    localparam int unsigned CNT_W = 8;  // byte count width
    localparam int unsigned RXQ_DEPTH = 128;  // rx queue capacity in bytes
    localparam int unsigned RXQ_PTR_W = 7;  // rx queue pointer width
    localparam int unsigned REV_CHUNK = 16;  // reversed copy staging depth

    // instruction codes on cmd_op
    localparam logic [2:0] OP_RXQ_TO_RAM = 3'h0;  // rxq_to_ram_move
    localparam logic [2:0] OP_RAM_TO_TXQ = 3'h1;  // ram_to_txq_copy
    localparam logic [2:0] OP_FWD_COPY = 3'h2;  // forward_block_copy
    localparam logic [2:0] OP_REV_COPY = 3'h3;  // reversed_block_copy
    localparam logic [2:0] OP_XOR_BLOCK = 3'h4;  // xor_combine_block

    // engine sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_RDA, ST_WA, ST_CA, ST_RDB, ST_WB, ST_CB,
        ST_WR, ST_TXW, ST_NXT, ST_RVW, ST_FIN
    } mbm_state_type;

endpackage : mbm_pkg

`default_nettype wire

// ===== verilog/mbm_engine.sv
// memory block move engine with its own rx queue.
// assumes a sync ram: it samples addr/re/we at an edge and returns read
// data during the following cycle; rx bytes and commands are synchronous.
// Behaviour
// [R1] overlapping blocks handled for all but reversed
// [R2] reversed copy overlap safe only up to 16
// [R3] one-byte upward shift copy stays intact
// [R4] rx queue bytes moved into ram
// [R5] ram block appended to tx queue
// [R6] forward copy keeps byte order
// [R7] reversed copy writes byte n to E+C-1-n
// [R8] xor two blocks into the second
// [R9] same source and target clears ram
// [R10] rx queue holds up to 128 bytes
// [R11] empty rx read flags underflow unless byte arrives
// [R12] one instruction completes before the next starts
`timescale 1ns/1ns
`default_nettype none

module mbm_engine (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_count,
    input wire logic [9:0] cmd_src,
    input wire logic [9:0] cmd_dst,
    output logic cmd_done,
    output logic [9:0] ram_addr,
    output logic ram_re,
    output logic ram_we,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire logic rxq_push,
    input wire logic [7:0] rxq_data,
    output logic [7:0] rxq_level,
    output logic rxq_underflow,
    output logic txq_valid,
    output logic [7:0] txq_data,
    input wire logic txq_ready
);

    ////////////////////////////////////////////////////////////////////////
    // state record: every flip-flop of the block lives here
    typedef struct packed {
        mbm_pkg::mbm_state_type st;  // sequencer state
        logic [2:0] op;  // latched instruction
        logic [9:0] src;  // source base
        logic [9:0] dst;  // destination base
        logic [7:0] cnt;  // byte count
        logic [7:0] p;  // bytes processed so far
        logic [4:0] j;  // index inside a reversed chunk
        logic [4:0] k;  // length of current reversed chunk
        logic down;  // walk from the top end
        logic [7:0] a;  // byte in flight
        logic [15:0][7:0] rbuf;  // reversed copy staging
        logic [127:0][7:0] rxq;  // rx queue storage
        logic [6:0] head;  // rx queue read pointer
        logic [6:0] tail;  // rx queue write pointer
        logic [7:0] level;  // rx queue fill
        logic [9:0] ram_addr;
        logic [7:0] ram_wdata;
        logic ram_we;
        logic ram_re;
        logic tx_valid;
        logic [7:0] tx_data;
        logic uflow;
        logic done;
        logic cmd_ready;
    } mbm_reg_type;

    mbm_reg_type s_q;  // registered state
    mbm_reg_type s_d;  // next state
    logic pop;  // engine takes an rx byte this cycle
    logic pop_real;  // a stored byte leaves the queue
    logic push_real;  // an arriving byte is stored

    // base plus offset, wrapping inside the ram address space
    function automatic logic [9:0] mbm_offs(input logic [9:0] base,
                                            input logic [7:0] off);
        return base + {2'b00, off};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [7:0] off;
        logic [7:0] rem;
        off = s_q.down ? (s_q.cnt - 8'h01 - s_q.p) : s_q.p;  // R1
        rem = s_q.cnt - s_q.p;
        s_d = s_q;
        s_d.ram_we = 1'b0;
        s_d.ram_re = 1'b0;
        s_d.uflow = 1'b0;
        s_d.done = 1'b0;
        pop = 1'b0;
        case (s_q.st)
            mbm_pkg::ST_IDLE: begin
                // only idle takes a command, so instructions never mix
                if (cmd_valid && s_q.cmd_ready) begin
                    s_d.cmd_ready = 1'b0;  // R12
                    s_d.op = cmd_op;
                    s_d.src = cmd_src;
                    s_d.dst = cmd_dst;
                    s_d.cnt = cmd_count;
                    s_d.p = 8'h00;
                    s_d.j = 5'h00;
                    // upward overlap would clobber unread source bytes
                    s_d.down = (cmd_op == mbm_pkg::OP_FWD_COPY ||
                                cmd_op == mbm_pkg::OP_XOR_BLOCK) &&
                               (cmd_dst > cmd_src);  // R1 R3
                    s_d.st = (cmd_count == 8'h00) ? mbm_pkg::ST_FIN
                                                  : mbm_pkg::ST_RDA;
                end
            end
            mbm_pkg::ST_RDA: begin
                if (s_q.op == mbm_pkg::OP_RXQ_TO_RAM) begin
                    pop = 1'b1;  // R4
                    if (s_q.level != 8'h00) begin
                        s_d.a = s_q.rxq[s_q.head];
                    end else if (rxq_push) begin
                        s_d.a = rxq_data;  // R11
                    end else begin
                        s_d.a = 8'h00;
                        s_d.uflow = 1'b1;  // R11
                    end
                    s_d.st = mbm_pkg::ST_WR;
                end else begin
                    // a fresh chunk stages at most sixteen bytes
                    if (s_q.j == 5'h00) begin
                        s_d.k = (rem > 8'(mbm_pkg::REV_CHUNK)) ?
                            5'(mbm_pkg::REV_CHUNK) : rem[4:0];  // R2
                    end
                    s_d.ram_addr = mbm_offs(s_q.src, off);
                    s_d.ram_re = 1'b1;
                    s_d.st = mbm_pkg::ST_WA;
                end
            end
            mbm_pkg::ST_WA: begin
                s_d.st = mbm_pkg::ST_CA;  // ram is sampling the read
            end
            mbm_pkg::ST_CA: begin
                case (s_q.op)
                    mbm_pkg::OP_RAM_TO_TXQ: begin
                        s_d.tx_valid = 1'b1;  // R5
                        s_d.tx_data = ram_rdata;
                        s_d.st = mbm_pkg::ST_TXW;
                    end
                    mbm_pkg::OP_XOR_BLOCK: begin
                        s_d.a = ram_rdata;
                        s_d.st = mbm_pkg::ST_RDB;
                    end
                    mbm_pkg::OP_REV_COPY: begin
                        // whole chunk read before any write: R2
                        s_d.rbuf[s_q.j[3:0]] = ram_rdata;
                        s_d.p = s_q.p + 8'h01;
                        if (s_q.j == s_q.k - 5'h01) begin
                            s_d.j = 5'h00;
                            s_d.st = mbm_pkg::ST_RVW;
                        end else begin
                            s_d.j = s_q.j + 5'h01;
                            s_d.st = mbm_pkg::ST_RDA;
                        end
                    end
                    default: begin
                        s_d.a = ram_rdata;  // R6
                        s_d.st = mbm_pkg::ST_WR;
                    end
                endcase
            end
            mbm_pkg::ST_RDB: begin
                s_d.ram_addr = mbm_offs(s_q.dst, off);
                s_d.ram_re = 1'b1;
                s_d.st = mbm_pkg::ST_WB;
            end
            mbm_pkg::ST_WB: begin
                s_d.st = mbm_pkg::ST_CB;
            end
            mbm_pkg::ST_CB: begin
                s_d.a = s_q.a ^ ram_rdata;  // R8 R9
                s_d.st = mbm_pkg::ST_WR;
            end
            mbm_pkg::ST_WR: begin
                s_d.ram_addr = mbm_offs(s_q.dst, off);  // R6
                s_d.ram_wdata = s_q.a;
                s_d.ram_we = 1'b1;
                s_d.st = mbm_pkg::ST_NXT;
            end
            mbm_pkg::ST_TXW: begin
                // the tx queue may stall; byte stands until taken
                if (txq_ready) begin
                    s_d.tx_valid = 1'b0;  // R5
                    s_d.st = mbm_pkg::ST_NXT;
                end
            end
            mbm_pkg::ST_NXT: begin
                s_d.p = s_q.p + 8'h01;
                s_d.st = (s_q.p + 8'h01 == s_q.cnt) ? mbm_pkg::ST_FIN
                                                    : mbm_pkg::ST_RDA;
            end
            mbm_pkg::ST_RVW: begin
                // source byte (p-k+j) lands at dst+C-1-(p-k+j)
                s_d.ram_addr = mbm_offs(s_q.dst, s_q.cnt - 8'h01 -
                    (s_q.p - {3'b000, s_q.k}) - {3'b000, s_q.j});  // R7
                s_d.ram_wdata = s_q.rbuf[s_q.j[3:0]];
                s_d.ram_we = 1'b1;
                if (s_q.j == s_q.k - 5'h01) begin
                    s_d.j = 5'h00;
                    s_d.st = (s_q.p == s_q.cnt) ? mbm_pkg::ST_FIN
                                                : mbm_pkg::ST_RDA;
                end else begin
                    s_d.j = s_q.j + 5'h01;
                end
            end
            mbm_pkg::ST_FIN: begin
                s_d.done = 1'b1;  // R12
                s_d.cmd_ready = 1'b1;
                s_d.st = mbm_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = mbm_pkg::ST_IDLE;
            end
        endcase
        // rx queue: a byte bypassed to an empty-queue read is not stored
        pop_real = pop && (s_q.level != 8'h00);
        push_real = rxq_push && !(pop && s_q.level == 8'h00) &&
                    (s_q.level < 8'(mbm_pkg::RXQ_DEPTH));  // R10
        if (pop_real) begin
            s_d.head = s_q.head + 7'h01;
        end
        if (push_real) begin
            s_d.rxq[s_q.tail] = rxq_data;  // R10
            s_d.tail = s_q.tail + 7'h01;
        end
        s_d.level = s_q.level + {7'h00, push_real} - {7'h00, pop_real};
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.cmd_ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ready = s_q.cmd_ready;
    assign cmd_done = s_q.done;
    assign ram_addr = s_q.ram_addr;
    assign ram_re = s_q.ram_re;
    assign ram_we = s_q.ram_we;
    assign ram_wdata = s_q.ram_wdata;
    assign rxq_level = s_q.level;
    assign rxq_underflow = s_q.uflow;
    assign txq_valid = s_q.tx_valid;
    assign txq_data = s_q.tx_data;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_read_pulse;
        ram_re ##1 !ram_re;
    endsequence
    AST_BUSY_AFTER_TAKE: assert property (s_take |=> !cmd_ready) // R12
        else $error("command taken while engine busy");
    AST_DONE_READY: assert property (cmd_done |-> cmd_ready) // R12
        else $error("done without ready");
    AST_UFLOW: assert property ((s_q.st == mbm_pkg::ST_RDA && // R11
        s_q.op == mbm_pkg::OP_RXQ_TO_RAM && rxq_level == 8'h00 &&
        !rxq_push) |=> rxq_underflow)
        else $error("missing rx underflow");
    AST_NO_UFLOW: assert property ((s_q.st == mbm_pkg::ST_RDA && // R11
        s_q.op == mbm_pkg::OP_RXQ_TO_RAM && rxq_level == 8'h00 && rxq_push)
        |=> !rxq_underflow ##1 (ram_we && ram_wdata == $past(rxq_data, 2)))
        else $error("underflow or wrong byte on coincident arrival");
    AST_LEVEL_MAX: assert property (rxq_level <= mbm_pkg::RXQ_DEPTH) // R10
        else $error("rx queue over capacity");
    AST_SRC_READ: assert property ((s_q.st == mbm_pkg::ST_RDA && // R6
        s_q.op != mbm_pkg::OP_RXQ_TO_RAM) |=> s_read_pulse)
        else $error("source read not issued");
    AST_TX_HOLD: assert property ((txq_valid && !txq_ready) // R5
        |=> txq_valid && $stable(txq_data))
        else $error("tx byte dropped under stall");
    AST_XOR_CLEAR: assert property ((ram_we && // R9
        s_q.op == mbm_pkg::OP_XOR_BLOCK && s_q.src == s_q.dst)
        |-> ram_wdata == 8'h00)
        else $error("self xor did not clear");
    AST_UP_DOWN: assert property ((s_take and // R3
        (cmd_op == mbm_pkg::OP_FWD_COPY && cmd_dst > cmd_src)) |=> s_q.down)
        else $error("upward overlap not walked from top");

endmodule // mbm_engine
`default_nettype wire

// ===== tb/mbm_ram_model.sv
// partner model: byte ram with one-cycle read latency, plus tx queue sink.
// assumes the engine moves its strobes just after rising edges.
`timescale 1ns/1ns
`default_nettype none

module mbm_ram_model (
    input wire logic sys_clk,
    input wire logic [9:0] ram_addr,
    input wire logic ram_re,
    input wire logic ram_we,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata,
    input wire logic txq_valid,
    input wire logic [7:0] txq_data,
    output logic txq_ready,
    input wire logic slow
);
    logic [7:0] mem [0:1023];  // ram contents, preset by the bench
    logic [7:0] txlog [$];  // bytes taken into the tx queue
    logic [1:0] tick = 2'h0;  // stall pattern counter
    // when slow, ready is low three cycles in four to stretch the handshake
    assign txq_ready = !slow || (tick == 2'h0);
    // read data holds until the next read, as a plain sync ram does
    always @(posedge sys_clk) begin
        tick <= tick + 2'h1;
        if (ram_re)
            ram_rdata <= mem[ram_addr];
        if (ram_we)
            mem[ram_addr] <= ram_wdata;
        if (txq_valid && txq_ready)
            txlog.push_back(txq_data);
    end
endmodule // mbm_ram_model

`default_nettype wire

// ===== tb/mbm_engine_test.sv
// testbench of the memory block move engine.
// assumes the partner ram model; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none

module mbm_engine_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [7:0] cmd_count = 8'h00;
    logic [9:0] cmd_src = 10'h000;
    logic [9:0] cmd_dst = 10'h000;
    logic rxq_push = 1'b0;
    logic [7:0] rxq_data = 8'h00;
    logic slow = 1'b0;
    wire logic cmd_ready, cmd_done, ram_re, ram_we, rxq_underflow;
    wire logic txq_valid, txq_ready;
    wire logic [9:0] ram_addr;
    wire logic [7:0] ram_wdata, ram_rdata, rxq_level, txq_data;
    int n_mismatch = 0;
    int check_count = 0;
    int n_under = 0;  // underflow pulses seen
    logic [7:0] snap [0:1023];  // ram image before each command

    always #50 sys_clk = ~sys_clk;

    mbm_engine dut_u (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_count(cmd_count),
        .cmd_src(cmd_src), .cmd_dst(cmd_dst), .cmd_done(cmd_done),
        .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we),
        .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .rxq_push(rxq_push),
        .rxq_data(rxq_data), .rxq_level(rxq_level),
        .rxq_underflow(rxq_underflow), .txq_valid(txq_valid),
        .txq_data(txq_data), .txq_ready(txq_ready));
    mbm_ram_model ram_u (.sys_clk(sys_clk), .ram_addr(ram_addr),
        .ram_re(ram_re), .ram_we(ram_we), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .txq_valid(txq_valid), .txq_data(txq_data),
        .txq_ready(txq_ready), .slow(slow));

    // underflow is a one-cycle pulse, so the falling edge catches it
    always @(negedge sys_clk) begin
        if (rxq_underflow === 1'b1)
            n_under++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // offer one command, hold it until taken, then wait for done
    task automatic run_cmd(input logic [2:0] op, input logic [7:0] c,
            input logic [9:0] a, input logic [9:0] e);
        int k;
        @(negedge sys_clk);
        for (k = 0; k < 1024; k++)
            snap[k] = ram_u.mem[k];
        cmd_op = op;
        cmd_count = c;
        cmd_src = a;
        cmd_dst = e;
        cmd_valid = 1'b1;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        k = 0;
        while (cmd_done !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        chk8({7'h00, cmd_done}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // forward copy, overlapping upward by one and downward by two
    task automatic t_fwd;
        int n;
        run_cmd(mbm_pkg::OP_FWD_COPY, 8'h09, 10'h22a, 10'h22b);
        for (n = 0; n < 9; n++)
            chk8(ram_u.mem[10'h22b + n], snap[10'h22a + n]);
        chk8(ram_u.mem[10'h22a], snap[10'h22a]);
        run_cmd(mbm_pkg::OP_FWD_COPY, 8'h05, 10'h150, 10'h14e);
        for (n = 0; n < 5; n++)
            chk8(ram_u.mem[10'h14e + n], snap[10'h150 + n]);
    endtask

    // reversed copy: overlap kept to 16 bytes, then 20 bytes with blocks 64 bytes apart
    task automatic t_rev;
        int n;
        run_cmd(mbm_pkg::OP_REV_COPY, 8'h10, 10'h100, 10'h104);
        for (n = 0; n < 16; n++)
            chk8(ram_u.mem[10'h104 + 15 - n], snap[10'h100 + n]);
        run_cmd(mbm_pkg::OP_REV_COPY, 8'h14, 10'h180, 10'h1c0);
        for (n = 0; n < 20; n++)
            chk8(ram_u.mem[10'h1c0 + 19 - n], snap[10'h180 + n]);
    endtask

    // xor into the second block, then self-xor as a clear
    task automatic t_xor;
        int n;
        logic [7:0] want;  // expected xor byte
        run_cmd(mbm_pkg::OP_XOR_BLOCK, 8'h08, 10'h040, 10'h060);
        for (n = 0; n < 8; n++) begin
            want = snap[10'h040 + n] ^ snap[10'h060 + n];
            chk8(ram_u.mem[10'h060 + n], want);
        end
        run_cmd(mbm_pkg::OP_XOR_BLOCK, 8'h05, 10'h070, 10'h070);
        for (n = 0; n < 5; n++)
            chk8(ram_u.mem[10'h070 + n], 8'h00);
    endtask

    // three rx bytes, four moved: the last read finds the queue empty
    task automatic t_rxq;
        int n;
        int u0;
        for (n = 1; n < 4; n++) begin
            @(negedge sys_clk);
            rxq_push = 1'b1;
            rxq_data = 8'(n * 8'h11);
            @(negedge sys_clk);
            rxq_push = 1'b0;
        end
        @(negedge sys_clk);
        chk8(rxq_level, 8'h03);
        u0 = n_under;
        run_cmd(mbm_pkg::OP_RXQ_TO_RAM, 8'h04, 10'h000, 10'h300);
        for (n = 0; n < 3; n++)
            chk8(ram_u.mem[10'h300 + n], 8'(n * 8'h11 + 8'h11));
        chk8(ram_u.mem[10'h303], 8'h00);
        chk8(8'(n_under - u0), 8'h01);
        chk8(rxq_level, 8'h00);
        // one byte moved while a byte arrives at the empty-queue read
        u0 = n_under;
        fork
            run_cmd(mbm_pkg::OP_RXQ_TO_RAM, 8'h01, 10'h000, 10'h310);
            begin
                // take edge, then the read edge sees the arrival
                repeat (2) @(negedge sys_clk);
                rxq_push = 1'b1;
                rxq_data = 8'h5a;
                @(negedge sys_clk);
                rxq_push = 1'b0;
            end
        join
        chk8(ram_u.mem[10'h310], 8'h5a);
        chk8(8'(n_under - u0), 8'h00);
        chk8(rxq_level, 8'h00);
    endtask

    // fill the rx queue one byte past capacity, then drain all of it
    task automatic t_rxq_fill;
        int n;
        for (n = 0; n < 129; n++) begin
            @(negedge sys_clk);
            rxq_push = 1'b1;
            rxq_data = 8'(n);
        end
        @(negedge sys_clk);
        rxq_push = 1'b0;
        chk8(rxq_level, 8'h80);
        run_cmd(mbm_pkg::OP_RXQ_TO_RAM, 8'h80, 10'h000, 10'h280);
        for (n = 0; n < 128; n++)
            chk8(ram_u.mem[10'h280 + n], 8'(n));
        chk8(rxq_level, 8'h00);
    endtask

    // ram block to tx queue while the sink stalls
    task automatic t_tx;
        int n;
        slow = 1'b1;
        run_cmd(mbm_pkg::OP_RAM_TO_TXQ, 8'h05, 10'h200, 10'h000);
        slow = 1'b0;
        chk8(8'(ram_u.txlog.size()), 8'h05);
        for (n = 0; n < 5 && ram_u.txlog.size() > 0; n++)
            chk8(ram_u.txlog.pop_front(), snap[10'h200 + n]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // main sequence: preset ram, reset for three cycles, run scenarios
    initial begin
        for (int k = 0; k < 1024; k++)
            ram_u.mem[k] = 8'(k * 7 + 3);
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        t_fwd;
        t_rev;
        t_xor;
        t_rxq;
        t_rxq_fill;
        t_tx;
        print_verdict;
    end

    // watchdog: far beyond the thousand or so cycles the scenarios need
    initial begin
        #2000000;
        n_mismatch++;
        print_verdict;
    end
endmodule // mbm_engine_test

`default_nettype wire
